// ---- mcusfr_params.svh ----
`ifndef MCUSFR_PARAMS_SVH
`define MCUSFR_PARAMS_SVH
// R page offsets at byte address 4*index; IOC page sits at 0x40 plus 4*index.
`define MCUSFR_IOC_PAGE_BASE 8'h40
`define MCUSFR_IDX_TIMER_COUNT 4'h1
`define MCUSFR_IDX_TIMER_CONTROL 4'h1
`define MCUSFR_IDX_CPU_STATUS 4'h3
`define MCUSFR_IDX_RAM_SELECT 4'h4
`define MCUSFR_IDX_PORT5 4'h5
`define MCUSFR_IDX_PORT6 4'h6
`define MCUSFR_IDX_PORT7 4'h7
`define MCUSFR_IDX_WAKEUP 4'ha
`define MCUSFR_IDX_WATCHDOG 4'ha
`define MCUSFR_IDX_NV_CONTROL 4'hb
`define MCUSFR_IDX_PULL_DOWN 4'hb
`define MCUSFR_IDX_NV_ADDRESS 4'hc
`define MCUSFR_IDX_OPEN_DRAIN 4'hc
`define MCUSFR_IDX_NV_DATA 4'hd
`define MCUSFR_IDX_PULL_HIGH 4'hd
`define MCUSFR_IDX_LOW_VOLTAGE 4'he
`define MCUSFR_IDX_IRQ_FLAGS 4'hf
`define MCUSFR_IDX_IRQ_MASK 4'hf
`define MCUSFR_IDX_INSTR 4'h8
// Field positions.
`define MCUSFR_ST_TIMEOUT 4
`define MCUSFR_ST_POWERDOWN 3
`define MCUSFR_ST_ZERO 2
`define MCUSFR_NV_RD 7
`define MCUSFR_NV_WR 6
`define MCUSFR_NV_WE 5
`define MCUSFR_NV_BUSY 4
`define MCUSFR_NV_PWR 3
`define MCUSFR_TC_GIE 6
`define MCUSFR_WD_EN 7
`define MCUSFR_WD_EIS 6
// Reset values.
`define MCUSFR_RST_TIMER_CONTROL 8'h3f
`define MCUSFR_RST_WATCHDOG 8'hcf
`define MCUSFR_RST_ALL_ONES 8'hff
`define MCUSFR_RST_ZERO 8'h00
`define MCUSFR_RST_STATUS 8'h18
// Timing counts in instruction clocks.
`define MCUSFR_NV_READ_CYCLES 4
`define MCUSFR_NV_WRITE_CYCLES 4000
`define MCUSFR_WDT_PERIOD 4000
`endif

// ---- mcusfr_pkg.sv ----
`default_nettype none
package mcusfr_pkg;
	typedef enum logic [1:0] {NV_IDLE, NV_READING, NV_WRITING} mcusfr_nv_e;
	typedef logic [7:0] mcusfr_byte_t;
endpackage
`default_nettype wire

// ---- mcusfr_top.sv ----
`include "mcusfr_params.svh"
`default_nettype none
// Function
// RULE_01: Timeout set by sleep, wdt-clear, power-up; cleared by watchdog timeout; power-down flag likewise (code: sleep clears it, timeout leaves it).
// RULE_02: ram_select low six bits give indirect address, bit 6 chooses bank.
// RULE_03: ram_select bit 7 always reads zero.
// RULE_04: Zero flag set when ram_select equals 3F.
// RULE_05: Wakeup bit 6 enables port 6 change wakeup; other bits read zero.
// RULE_06: Read start bit launches EEPROM read; hardware clears it when done.
// RULE_07: Write start bit launches EEPROM write; hardware clears it when done.
// RULE_08: EEPROM writes blocked unless write enable is one.
// RULE_09: Busy flag is one while an EEPROM write is in progress.
// RULE_10: Power bit zero switches EEPROM off.
// RULE_11: Address is seven bits, top bit zero; data register full byte.
// RULE_12: Low-voltage status reads zero when low, one when fine or disabled.
// RULE_13: Two-bit level field selects four ascending thresholds.
// RULE_14: Low-voltage flag set at or below threshold; cleared only by software.
// RULE_15: Flags latch falling external edge, port 6 change, timer overflow.
// RULE_16: Flag reads return flags AND mask; writes only clear flags.
// RULE_17: Global enable cleared by disable or interrupt, set by enable or return.
// RULE_18: Timer source selects clock or pin; edge bit selects rising or falling.
// RULE_19: Timer prescaler off is 1:1, else 1:2 to 1:256.
// RULE_20: Direction bit one makes pin high impedance, zero drives it.
// RULE_21: Watchdog enable bit and prescaler encoded like the timer.
// RULE_22: External-irq select makes P60 interrupt input; pin stays readable.
// RULE_23: Pull enables active low; pull-down bit map; open-drain active high.
// RULE_24: Only a timer count write clears the timer prescaler.
// RULE_25: Watchdog clear or sleep clears watchdog counter and prescaler.
// RULE_26: Interrupt request when flag, mask and global enable are all set.
module mcusfr_top #(
	parameter int NV_WRITE_CYCLES = `MCUSFR_NV_WRITE_CYCLES,
	parameter int WDT_PERIOD = `MCUSFR_WDT_PERIOD
) (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [7:0] PORT5_PIN_I,
	output logic [7:0] PORT5_OUT_O,
	output logic [7:0] PORT5_OE_O,
	input wire logic [7:0] PORT6_PIN_I,
	output logic [7:0] PORT6_OUT_O,
	output logic [7:0] PORT6_OE_O,
	input wire logic [7:0] PORT7_PIN_I,
	output logic [7:0] PORT7_OUT_O,
	output logic [7:0] PORT7_OE_O,
	output logic [7:0] PULL_DOWN_EN_O,
	output logic [7:0] PULL_HIGH_EN_O,
	input wire logic TIMER_PIN_I,
	input wire logic LOW_VOLTAGE_I,
	input wire logic LV_FLAG_TRIP_I,
	output logic [1:0] LV_LEVEL_O,
	output logic LV_DETECT_EN_O,
	output logic IRQ_O,
	output logic WAKEUP_O,
	output logic WDT_RESET_O,
	output logic [6:0] RAM_SELECT_ADDR_O,
	output logic RAM_BANK_O,
	output logic NV_POWER_O,
	output logic NV_WE_O,
	output logic NV_RE_O,
	output logic [6:0] NV_ADDR_O,
	output logic [7:0] NV_WDATA_O,
	input wire logic [7:0] NV_RDATA_I
);
	import mcusfr_pkg::*;

	function automatic logic [8:0] ratio_limit(input logic en, input logic [2:0] sel);
		ratio_limit = en ? (9'h002 << sel) : 9'h001;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	logic [29:0] sync_a;
	logic [29:0] sync_b;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {LV_FLAG_TRIP_I, LOW_VOLTAGE_I, TIMER_PIN_I, PORT7_PIN_I[0],
				PORT6_PIN_I, PORT5_PIN_I, 2'b00, PORT7_PIN_I[7:1], 1'b0};
			sync_b <= sync_a;
		end
	end
	wire [7:0] p5_in = sync_b[17:10];
	wire [7:0] p6_in = sync_b[25:18];
	wire [7:0] p7_in = {sync_b[7:1], sync_b[26]};
	wire tmr_pin = sync_b[27];
	wire lv_low = sync_b[28];
	wire lv_trip = sync_b[29];
	logic [7:0] p6_prev;
	logic tmr_prev;
	// Edge detectors wait for real pin levels, so idle-high pins give no false edge after reset.
	logic [2:0] sync_fill;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			p6_prev <= '0;
			tmr_prev <= 1'b0;
			sync_fill <= '0;
		end else begin
			p6_prev <= p6_in;
			tmr_prev <= tmr_pin;
			sync_fill <= {sync_fill[1:0], 1'b1};
		end
	end
	wire pins_ready = sync_fill[2];

	//////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: one write and one read outstanding.
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
	assign S_AXI_WREADY_O = !w_held && !S_AXI_BVALID_O;
	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
	wire aw_now = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
	wire w_now = S_AXI_WVALID_I && S_AXI_WREADY_O;
	wire [7:0] wa = aw_held ? aw_addr : S_AXI_AWADDR_I;
	wire [31:0] wd = w_held ? w_data : S_AXI_WDATA_I;
	wire wlane = w_held ? w_strb[0] : S_AXI_WSTRB_I[0];
	wire wr_go = (aw_held || aw_now) && (w_held || w_now);
	wire wr_ok = wr_go && wlane && (wa[1:0] == 2'b00) && !wa[7];
	wire [7:0] wv = wd[7:0];
	function automatic logic hit(input logic [7:0] a, input logic ioc, input logic [3:0] idx);
		hit = (a == ((ioc ? `MCUSFR_IOC_PAGE_BASE : 8'h00) | {2'b00, idx, 2'b00}));
	endfunction
	wire w_tcount = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_TIMER_COUNT);
	wire w_tctrl = wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_TIMER_CONTROL);
	wire w_status = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_CPU_STATUS);
	wire w_rsel = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_RAM_SELECT);
	wire w_instr = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_INSTR);
	wire w_wake = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_WAKEUP);
	wire w_wdog = wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_WATCHDOG);
	wire w_nvc = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_NV_CONTROL);
	wire w_pd = wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_PULL_DOWN);
	wire w_nva = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_NV_ADDRESS);
	wire w_od = wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_OPEN_DRAIN);
	wire w_nvd = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_NV_DATA);
	wire w_ph = wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_PULL_HIGH);
	wire w_lvc = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_LOW_VOLTAGE);
	wire w_flg = wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_IRQ_FLAGS);
	wire w_msk = wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_IRQ_MASK);
	// Instruction strobes: bit0 sleep, 1 watchdog clear, 2 enable, 3 disable, 4 return.
	wire i_sleep = w_instr && wv[0];
	wire i_watchdog_clear_instr = w_instr && wv[1];
	wire i_eni = w_instr && (wv[2] || wv[4]);
	wire i_global_irq_disable_instr = w_instr && wv[3];
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			S_AXI_BVALID_O <= 1'b0;
		end else begin
			if (aw_now)
				aw_addr <= S_AXI_AWADDR_I;
			if (w_now) begin
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end
			aw_held <= wr_go ? 1'b0 : (aw_held || aw_now);
			w_held <= wr_go ? 1'b0 : (w_held || w_now);
			if (wr_go)
				S_AXI_BVALID_O <= 1'b1;
			else if (S_AXI_BREADY_I)
				S_AXI_BVALID_O <= 1'b0;
		end
	end
	assign S_AXI_BRESP_O = 2'b00;

	//////////////////////////////////////////////////////////////////////////////
	// Registers.
	mcusfr_byte_t timer_count, timer_control, cpu_status, ram_select, wakeup_control;
	mcusfr_byte_t watchdog_control, pull_down_control, open_drain_control, pull_high_control;
	mcusfr_byte_t port5_data, port6_data, port7_data, port5_dir, port6_dir, port7_dir;
	mcusfr_byte_t nv_address, nv_data, interrupt_mask;
	logic [3:0] nv_ctl;
	logic [1:0] low_voltage_level_select;
	logic low_voltage_detector_enable;
	logic [3:0] irq_flags;
	logic [8:0] tmr_pre, wdt_pre;
	logic [12:0] wdt_cnt;
	logic [12:0] nv_cnt;
	mcusfr_nv_e nv_state;
	wire wdt_timeout;
	wire irq_raise = IRQ_O;

	wire [7:0] pw5 = hit(wa, 1'b0, `MCUSFR_IDX_PORT5) && wr_ok ? 8'h01 : 8'h00;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			port5_data <= '0;
			port6_data <= '0;
			port7_data <= '0;
			port5_dir <= `MCUSFR_RST_ALL_ONES;
			port6_dir <= `MCUSFR_RST_ALL_ONES;
			port7_dir <= `MCUSFR_RST_ALL_ONES;
		end else begin
			if (pw5[0]) port5_data <= wv;
			if (wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_PORT6)) port6_data <= wv;
			if (wr_ok && hit(wa, 1'b0, `MCUSFR_IDX_PORT7)) port7_data <= wv;
			if (wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_PORT5)) port5_dir <= wv;
			if (wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_PORT6)) port6_dir <= wv;
			if (wr_ok && hit(wa, 1'b1, `MCUSFR_IDX_PORT7)) port7_dir <= wv;
		end
	end
	assign PORT5_OUT_O = port5_data;
	assign PORT6_OUT_O = port6_data;
	assign PORT7_OUT_O = port7_data;
	assign PORT5_OE_O = ~port5_dir; // RULE_20
	// Open-drain pins drive only the low level.
	assign PORT6_OE_O = ~port6_dir & ~(open_drain_control & port6_data); // RULE_20 RULE_23
	assign PORT7_OE_O = ~port7_dir;
	assign PULL_DOWN_EN_O = ~pull_down_control; // RULE_23
	assign PULL_HIGH_EN_O = ~pull_high_control; // RULE_23

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			timer_control <= `MCUSFR_RST_TIMER_CONTROL;
			watchdog_control <= `MCUSFR_RST_WATCHDOG;
			pull_down_control <= `MCUSFR_RST_ALL_ONES;
			pull_high_control <= `MCUSFR_RST_ALL_ONES;
			open_drain_control <= `MCUSFR_RST_ZERO;
			wakeup_control <= '0;
			ram_select <= '0;
			interrupt_mask <= '0;
			nv_address <= '0;
			low_voltage_level_select <= '0;
			low_voltage_detector_enable <= 1'b0;
		end else begin
			if (w_tctrl) timer_control <= {1'b0, wv[6:0]};
			if (i_eni) timer_control[`MCUSFR_TC_GIE] <= 1'b1; // RULE_17
			if (i_global_irq_disable_instr || irq_raise) timer_control[`MCUSFR_TC_GIE] <= 1'b0; // RULE_17
			if (w_wdog) watchdog_control <= {wv[7:6], 2'b00, wv[3:0]}; // RULE_21
			if (w_pd) pull_down_control <= wv;
			if (w_ph) pull_high_control <= wv;
			if (w_od) open_drain_control <= wv;
			if (w_wake) wakeup_control <= {1'b0, wv[6], 6'h00}; // RULE_05
			if (w_rsel) ram_select <= {1'b0, wv[6:0]}; // RULE_03
			if (w_msk) interrupt_mask <= {wv[7], 4'h0, wv[2:0]};
			if (w_nva) nv_address <= {1'b0, wv[6:0]}; // RULE_11
			if (w_lvc) begin
				low_voltage_detector_enable <= wv[3];
				low_voltage_level_select <= wv[1:0]; // RULE_13
			end
		end
	end
	assign RAM_SELECT_ADDR_O = {1'b0, ram_select[5:0]}; // RULE_02
	assign RAM_BANK_O = ram_select[6]; // RULE_02
	assign LV_LEVEL_O = low_voltage_level_select;
	assign LV_DETECT_EN_O = low_voltage_detector_enable;
	wire low_voltage_status_n = !(low_voltage_detector_enable && lv_low); // RULE_12

	//////////////////////////////////////////////////////////////////////////////
	// Timer with prescaler and pin edge selection.
	wire edge_rise = pins_ready && tmr_pin && !tmr_prev;
	wire edge_fall = pins_ready && !tmr_pin && tmr_prev;
	wire tmr_tick_src = timer_control[5] ? (timer_control[4] ? edge_fall : edge_rise) : 1'b1; // RULE_18
	wire [8:0] tmr_lim = ratio_limit(timer_control[3], timer_control[2:0]); // RULE_19
	wire tmr_step = tmr_tick_src && (tmr_pre + 9'h001 >= tmr_lim);
	wire tmr_ovf = tmr_step && (timer_count == 8'hff);
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			timer_count <= '0;
			tmr_pre <= '0;
		end else if (w_tcount) begin
			timer_count <= wv;
			tmr_pre <= '0; // RULE_24
		end else if (tmr_tick_src) begin
			tmr_pre <= tmr_step ? 9'h000 : tmr_pre + 9'h001;
			if (tmr_step) timer_count <= timer_count + 8'h01;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Watchdog, status bits.
	wire [8:0] wdt_lim = ratio_limit(watchdog_control[3], watchdog_control[2:0]); // RULE_21
	wire wdt_step = (wdt_pre + 9'h001 >= wdt_lim);
	assign wdt_timeout = watchdog_control[`MCUSFR_WD_EN] && wdt_step &&
		(wdt_cnt == 13'(WDT_PERIOD - 1));
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wdt_pre <= '0;
			wdt_cnt <= '0;
			WDT_RESET_O <= 1'b0;
		end else begin
			WDT_RESET_O <= wdt_timeout;
			if (i_watchdog_clear_instr || i_sleep || !watchdog_control[`MCUSFR_WD_EN] || wdt_timeout) begin
				wdt_pre <= '0; // RULE_25
				wdt_cnt <= '0; // RULE_25
			end else begin
				wdt_pre <= wdt_step ? 9'h000 : wdt_pre + 9'h001;
				if (wdt_step) wdt_cnt <= wdt_cnt + 13'h0001;
			end
		end
	end
	wire zero_flag = (ram_select == 8'h3f); // RULE_04
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cpu_status <= `MCUSFR_RST_STATUS; // RULE_01
		end else begin
			if (w_status) cpu_status <= {wv[7:5], cpu_status[4:3], wv[2:0]};
			if (i_watchdog_clear_instr) cpu_status[4:3] <= 2'b11; // RULE_01
			if (i_sleep) cpu_status[4:3] <= 2'b10; // RULE_01
			if (wdt_timeout) cpu_status[`MCUSFR_ST_TIMEOUT] <= 1'b0; // RULE_01
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// EEPROM sequencer.
	wire nv_rd_req = w_nvc && wv[`MCUSFR_NV_RD] && nv_ctl[0] && nv_state == NV_IDLE;
	wire nv_wr_req = w_nvc && wv[`MCUSFR_NV_WR] && wv[`MCUSFR_NV_WE] && nv_ctl[0] &&
		nv_state == NV_IDLE; // RULE_08
	wire nv_done = (nv_state != NV_IDLE) && nv_cnt == 13'h0000;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			nv_state <= NV_IDLE;
			nv_cnt <= '0;
			nv_ctl <= '0;
			nv_data <= '0;
		end else begin
			if (w_nvc) nv_ctl <= {nv_ctl[3:2], wv[`MCUSFR_NV_WE], wv[`MCUSFR_NV_PWR]}; // RULE_10
			if (w_nvd) nv_data <= wv; // RULE_11
			case (nv_state)
				NV_IDLE: begin
					if (nv_rd_req) begin
						nv_state <= NV_READING; // RULE_06
						nv_cnt <= 13'(`MCUSFR_NV_READ_CYCLES - 1);
					end else if (nv_wr_req) begin
						nv_state <= NV_WRITING; // RULE_07
						nv_cnt <= 13'(NV_WRITE_CYCLES - 1);
					end
				end
				NV_READING: begin
					if (nv_done) begin
						nv_data <= NV_RDATA_I;
						nv_state <= NV_IDLE; // RULE_06
					end else nv_cnt <= nv_cnt - 13'h0001;
				end
				NV_WRITING: begin
					if (nv_done) nv_state <= NV_IDLE; // RULE_07 RULE_09
					else nv_cnt <= nv_cnt - 13'h0001;
				end
				default: nv_state <= NV_IDLE;
			endcase
		end
	end
	wire nv_busy = (nv_state == NV_WRITING); // RULE_09
	wire [7:0] nv_ctl_read = {nv_state == NV_READING, nv_busy, nv_ctl[1], nv_busy, nv_ctl[0],
		3'b000};
	assign NV_POWER_O = nv_ctl[0]; // RULE_10
	assign NV_RE_O = (nv_state == NV_READING);
	assign NV_WE_O = nv_busy;
	assign NV_ADDR_O = nv_address[6:0];
	assign NV_WDATA_O = nv_data;

	//////////////////////////////////////////////////////////////////////////////
	// Interrupt flags; a set in the same cycle as a clear wins.
	wire ext_pin = p6_in[0];
	wire ext_fall = pins_ready && watchdog_control[`MCUSFR_WD_EIS] &&
		!ext_pin && p6_prev[0]; // RULE_22
	wire p6_change = pins_ready && (p6_in != p6_prev);
	wire lv_set = low_voltage_detector_enable && lv_trip; // RULE_14
	wire [3:0] set_v = {lv_set, ext_fall, p6_change, tmr_ovf}; // RULE_15
	wire [3:0] clr_v = w_flg ? ~{wv[7], wv[2:0]} : 4'h0; // RULE_16
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) irq_flags <= '0;
		else irq_flags <= (irq_flags & ~clr_v) | set_v; // RULE_14 RULE_15 RULE_16
	end
	wire [3:0] mask_v = {interrupt_mask[7], interrupt_mask[2:0]};
	assign IRQ_O = |(irq_flags & mask_v) && timer_control[`MCUSFR_TC_GIE]; // RULE_26
	assign WAKEUP_O = wakeup_control[6] && p6_change; // RULE_05
	wire [7:0] flags_read = {irq_flags[3] & mask_v[3], 4'h0, irq_flags[2:0] & mask_v[2:0]};

	//////////////////////////////////////////////////////////////////////////////
	// Read path.
	wire [7:0] ra = S_AXI_ARADDR_I;
	wire [7:0] rsel = ra & 8'hbf;
	wire rioc = ra[6];
	logic [7:0] rd;
	logic rbad;
	always_comb begin
		rd = 8'h00;
		rbad = (ra[1:0] != 2'b00) || ra[7];
		case (rsel[5:2])
			4'h1: rd = rioc ? timer_control : timer_count;
			4'h3: rd = rioc ? 8'h00 : {cpu_status[7:3], zero_flag, cpu_status[1:0]}; // RULE_04
			4'h4: rd = rioc ? 8'h00 : {1'b0, ram_select[6:0]}; // RULE_03
			4'h5: rd = rioc ? port5_dir : p5_in;
			4'h6: rd = rioc ? port6_dir : p6_in; // RULE_22
			4'h7: rd = rioc ? port7_dir : p7_in;
			4'ha: rd = rioc ? watchdog_control : wakeup_control;
			4'hb: rd = rioc ? pull_down_control : nv_ctl_read;
			4'hc: rd = rioc ? open_drain_control : nv_address;
			4'hd: rd = rioc ? pull_high_control : nv_data;
			4'he: rd = rioc ? 8'h00 : {4'h0, low_voltage_detector_enable, low_voltage_status_n,
				low_voltage_level_select}; // RULE_12
			4'hf: rd = rioc ? interrupt_mask : flags_read; // RULE_16
			default: rd = 8'h00;
		endcase
	end
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= '0;
			S_AXI_RRESP_O <= 2'b00;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O <= {24'h000000, rd};
			S_AXI_RRESP_O <= rbad ? 2'b10 : 2'b00;
		end else if (S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end
endmodule // mcusfr_top
`default_nettype wire

// ---- mcusfr_top_asserts.sv ----
`default_nettype none
module mcusfr_top_asserts (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_BVALID_O,
	input wire logic [1:0] S_AXI_BRESP_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic S_AXI_RVALID_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic IRQ_O,
	input wire logic WDT_RESET_O,
	input wire logic [6:0] RAM_SELECT_ADDR_O,
	input wire logic NV_POWER_O,
	input wire logic NV_WE_O,
	input wire logic NV_RE_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
		else $error("write response dropped early");
	a_bresp_okay: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O == 2'b00)
		else $error("write response not okay");
	a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
		S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data changed while waiting");
	a_rdata_upper: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000)
		else $error("read data upper bits set");
	// A taken interrupt must drop the global enable, so the request lasts one cycle.
	a_irq_self_clear: assert property (IRQ_O |=> !IRQ_O)
		else $error("interrupt request held after being taken");
	a_wdt_pulse_once: assert property (WDT_RESET_O |=> !WDT_RESET_O)
		else $error("watchdog reset pulse too long");
	a_ram_addr_range: assert property (RAM_SELECT_ADDR_O[6] == 1'b0)
		else $error("indirect address out of range");
	a_nv_power_rw: assert property (NV_WE_O || NV_RE_O |-> NV_POWER_O)
		else $error("nonvolatile access while powered off");
	a_nv_read_end: assert property ($rose(NV_RE_O) |-> ##[1:6] !NV_RE_O)
		else $error("nonvolatile read never ends");
	a_nv_we_hold: assert property ($rose(NV_WE_O) |-> NV_WE_O [*8])
		else $error("nonvolatile write ended too soon");
	a_nv_rw_apart: assert property (!(NV_WE_O && NV_RE_O))
		else $error("read and write at once");
endmodule // mcusfr_top_asserts
bind mcusfr_top mcusfr_top_asserts u_chk (.SYS_CLK_I, .RESETN_I, .S_AXI_BREADY_I,
	.S_AXI_BVALID_O, .S_AXI_BRESP_O, .S_AXI_RREADY_I, .S_AXI_RVALID_O, .S_AXI_RDATA_O,
	.IRQ_O, .WDT_RESET_O, .RAM_SELECT_ADDR_O, .NV_POWER_O, .NV_WE_O, .NV_RE_O);
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mcusfr_pkg::*;
	logic SYS_CLK_I = 1'b0, RESETN_I = 1'b0, S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
	logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
	logic TIMER_PIN_I = 1'b0, LOW_VOLTAGE_I = 1'b0, LV_FLAG_TRIP_I = 1'b0;
	logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00, PORT5_PIN_I = 8'h00;
	logic [7:0] PORT6_PIN_I = 8'hff, PORT7_PIN_I = 8'h00, NV_RDATA_I = 8'h00;
	logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
	logic [3:0] S_AXI_WSTRB_I = 4'h1;
	logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
	logic IRQ_O, WAKEUP_O, WDT_RESET_O, RAM_BANK_O, NV_POWER_O, NV_WE_O, NV_RE_O, LV_DETECT_EN_O;
	logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, LV_LEVEL_O, rr;
	logic [7:0] PORT5_OUT_O, PORT5_OE_O, PORT6_OUT_O, PORT6_OE_O, PORT7_OUT_O, PORT7_OE_O;
	logic [7:0] PULL_DOWN_EN_O, PULL_HIGH_EN_O, NV_WDATA_O;
	logic [6:0] RAM_SELECT_ADDR_O, NV_ADDR_O;
	mcusfr_byte_t rv;
	int n_irq = 0;
	int errors = 0, n_compared = 0, cyc = 0;
	mcusfr_top #(.NV_WRITE_CYCLES(40), .WDT_PERIOD(4)) DUT (.SYS_CLK_I, .RESETN_I,
		.S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
		.S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
		.S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
		.S_AXI_RVALID_O, .S_AXI_RREADY_I, .PORT5_PIN_I, .PORT5_OUT_O, .PORT5_OE_O, .PORT6_PIN_I,
		.PORT6_OUT_O, .PORT6_OE_O, .PORT7_PIN_I, .PORT7_OUT_O, .PORT7_OE_O, .PULL_DOWN_EN_O,
		.PULL_HIGH_EN_O, .TIMER_PIN_I, .LOW_VOLTAGE_I, .LV_FLAG_TRIP_I, .LV_LEVEL_O,
		.LV_DETECT_EN_O, .IRQ_O, .WAKEUP_O, .WDT_RESET_O, .RAM_SELECT_ADDR_O, .RAM_BANK_O,
		.NV_POWER_O, .NV_WE_O, .NV_RE_O, .NV_ADDR_O, .NV_WDATA_O, .NV_RDATA_I);
	initial forever #4 SYS_CLK_I = ~SYS_CLK_I;
	// The request lasts one cycle, so it is caught by a monitor rather than polled.
	always @(posedge SYS_CLK_I) begin
		cyc <= cyc + 1;
		if (IRQ_O === 1'b1) n_irq <= n_irq + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end
	////////////////////////////////////////
	task automatic stop_test();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input mcusfr_byte_t d);
		bit aw = 1'b0;
		bit wd = 1'b0;
		@(posedge SYS_CLK_I);
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= {24'h0, d};
		S_AXI_AWVALID_I <= 1'b1;
		S_AXI_WVALID_I <= 1'b1;
		S_AXI_BREADY_I <= 1'b1;
		while (!(aw && wd)) begin
			@(posedge SYS_CLK_I);
			if (S_AXI_AWREADY_O) aw = 1'b1;
			if (S_AXI_WREADY_O) wd = 1'b1;
			S_AXI_AWVALID_I <= !aw;
			S_AXI_WVALID_I <= !wd;
		end
		do @(posedge SYS_CLK_I); while (!S_AXI_BVALID_O);
		S_AXI_BREADY_I <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge SYS_CLK_I);
		S_AXI_ARADDR_I <= a;
		S_AXI_ARVALID_I <= 1'b1;
		S_AXI_RREADY_I <= 1'b1;
		do @(posedge SYS_CLK_I); while (!S_AXI_ARREADY_O);
		S_AXI_ARVALID_I <= 1'b0;
		do @(posedge SYS_CLK_I); while (!S_AXI_RVALID_O);
		rv = S_AXI_RDATA_O[7:0];
		rr = S_AXI_RRESP_O;
		S_AXI_RREADY_I <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input mcusfr_byte_t e);
		rd(a);
		chk(rv, e);
	endtask
	task automatic poll(input logic [7:0] a, input mcusfr_byte_t m);
		for (int i = 0; i < 40; i++) begin
			rd(a);
			if ((rv & m) == 8'h00) break;
		end
	endtask
	task automatic pin(input logic b);
		@(posedge SYS_CLK_I);
		TIMER_PIN_I <= b;
		repeat (4) @(posedge SYS_CLK_I);
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		rc(8'h44, 8'h3f);
		rc(8'h68, 8'hcf);
		rc(8'h6c, 8'hff);
		rc(8'h70, 8'h00);
		rc(8'h7c, 8'h00);
		chk(PORT6_OE_O, 8'h00);
		chk(PULL_HIGH_EN_O, 8'h00);
		rd(8'h24);
		chk({6'h0, rr}, 8'h00);
		rd(8'h80);
		chk({6'h0, rr}, 8'h02);
	endtask
	task automatic t_ramsel();
		wr(8'h68, 8'h00);
		wr(8'h20, 8'h02);
		wr(8'h10, 8'hff);
		rc(8'h10, 8'h7f);
		chk({7'h0, RAM_BANK_O}, 8'h01);
		chk({1'b0, RAM_SELECT_ADDR_O}, 8'h3f);
		wr(8'h10, 8'h3f);
		rc(8'h0c, 8'h1c);
		wr(8'h10, 8'h3e);
		rc(8'h0c, 8'h18);
		wr(8'h28, 8'hff);
		rc(8'h28, 8'h40);
	endtask
	task automatic t_nv();
		wr(8'h30, 8'hff);
		rc(8'h30, 8'h7f);
		chk({1'b0, NV_ADDR_O}, 8'h7f);
		wr(8'h34, 8'ha5);
		rc(8'h34, 8'ha5);
		wr(8'h2c, 8'h08);
		chk({7'h0, NV_POWER_O}, 8'h01);
		wr(8'h2c, 8'h48);
		rc(8'h2c, 8'h08);
		wr(8'h2c, 8'h68);
		chk({7'h0, NV_WE_O}, 8'h01);
		chk(NV_WDATA_O, 8'ha5);
		rd(8'h2c);
		chk(rv & 8'h50, 8'h50);
		poll(8'h2c, 8'h50);
		rc(8'h2c, 8'h28);
		NV_RDATA_I <= 8'h3c;
		wr(8'h2c, 8'h88);
		poll(8'h2c, 8'h80);
		rc(8'h34, 8'h3c);
		wr(8'h2c, 8'h00);
		chk({7'h0, NV_POWER_O}, 8'h00);
	endtask
	task automatic t_lv();
		LOW_VOLTAGE_I <= 1'b1;
		wr(8'h38, 8'h03);
		rc(8'h38, 8'h07);
		for (int i = 0; i < 4; i++) begin
			wr(8'h38, 8'(8 + i));
			chk({6'h0, LV_LEVEL_O}, 8'(i));
			rc(8'h38, 8'(8 + i));
		end
		LOW_VOLTAGE_I <= 1'b0;
		repeat (2) @(posedge SYS_CLK_I);
		rc(8'h38, 8'h0f);
		LV_FLAG_TRIP_I <= 1'b1;
		wr(8'h7c, 8'h80);
		LV_FLAG_TRIP_I <= 1'b0;
		rc(8'h3c, 8'h80);
		wr(8'h3c, 8'h00);
		rc(8'h3c, 8'h00);
		wr(8'h3c, 8'hff);
		rc(8'h3c, 8'h00);
	endtask
	task automatic t_timer();
		wr(8'h44, 8'h20);
		wr(8'h04, 8'hff);
		wr(8'h7c, 8'h01);
		rc(8'h3c, 8'h00);
		pin(1'b1);
		rc(8'h3c, 8'h01);
		chk(8'(n_irq), 8'h00);
		wr(8'h20, 8'h04);
		@(posedge SYS_CLK_I);
		chk(8'(n_irq), 8'h01);
		rc(8'h44, 8'h20);
		wr(8'h3c, 8'h00);
		wr(8'h04, 8'hff);
		pin(1'b0);
		rc(8'h3c, 8'h00);
		wr(8'h44, 8'h30);
		pin(1'b1);
		pin(1'b0);
		rc(8'h3c, 8'h01);
		wr(8'h44, 8'h28);
		wr(8'h04, 8'hff);
		wr(8'h3c, 8'h00);
		pin(1'b1);
		rc(8'h3c, 8'h00);
		pin(1'b0);
		pin(1'b1);
		rc(8'h3c, 8'h01);
	endtask
	task automatic t_pins();
		wr(8'h68, 8'h40);
		wr(8'h7c, 8'h06);
		PORT6_PIN_I <= 8'hfe;
		repeat (4) @(posedge SYS_CLK_I);
		rc(8'h18, 8'hfe);
		rc(8'h3c, 8'h06);
		wr(8'h3c, 8'h00);
		wr(8'h68, 8'h00);
		PORT6_PIN_I <= 8'hff;
		repeat (4) @(posedge SYS_CLK_I);
		wr(8'h3c, 8'h00);
		PORT6_PIN_I <= 8'hfe;
		repeat (4) @(posedge SYS_CLK_I);
		rc(8'h3c, 8'h02);
		wr(8'h54, 8'h0f);
		chk(PORT5_OE_O, 8'hf0);
		wr(8'h6c, 8'h0f);
		chk(PULL_DOWN_EN_O, 8'hf0);
		wr(8'h74, 8'h00);
		chk(PULL_HIGH_EN_O, 8'hff);
		wr(8'h18, 8'hff);
		wr(8'h58, 8'h00);
		wr(8'h70, 8'h01);
		chk(PORT6_OE_O, 8'hfe);
	endtask
	task automatic t_status();
		wr(8'h20, 8'h01);
		rc(8'h0c, 8'h10);
		wr(8'h20, 8'h02);
		rc(8'h0c, 8'h18);
		wr(8'h68, 8'h80);
		for (int i = 0; i < 64 && WDT_RESET_O !== 1'b1; i++) @(posedge SYS_CLK_I);
		chk({7'h0, WDT_RESET_O}, 8'h01);
		wr(8'h68, 8'h00);
		rc(8'h0c, 8'h08);
	endtask
	initial begin
		repeat (20) @(posedge SYS_CLK_I);
		RESETN_I <= 1'b1;
		t_reset();
		t_ramsel();
		t_nv();
		t_lv();
		t_timer();
		t_pins();
		t_status();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
